// ---- logic/ram_defs.svh ----
// Constants of the on-chip RAM block decoder: address windows, block counts, capacities.
// Assumes byte addresses of 24 bits and sixteen-bit RAM words.
`ifndef RAM_DEFS_SVH
`define RAM_DEFS_SVH
`define RAM_ADDR_W 24
`define RAM_CPU_DP_HI 24'h00FFFF
`define RAM_CPU_SP_LO 24'h010000
`define RAM_CPU_SP_HI 24'h04FFFF
`define RAM_DMA_DP_LO 24'h010000
`define RAM_DMA_DP_HI 24'h01FFFF
`define RAM_DMA_SP_LO 24'h090000
`define RAM_DMA_SP_HI 24'h0CFFFF
`define RAM_MMR_BYTES 24'h0000C0
`define RAM_DP_BLOCKS 8
`define RAM_SP_BLOCKS 32
`define RAM_ALL_BLOCKS 40
`define RAM_BLOCK_WORDS 4096
`define RAM_DP_CAP 2'h2
`define RAM_SP_CAP 2'h1
`define RAM_MASTERS 8
`define RAM_M_DMA 0
`define RAM_M_USB 1
`define RAM_M_PROG 2
`define RAM_M_DR32 3
`define RAM_M_DR16A 4
`define RAM_M_DR16B 5
`define RAM_M_DW16A 6
`define RAM_M_DW16B 7
`endif

// ---- logic/ram_pkg.sv ----
// Types shared by the on-chip RAM block decoder and its users.
// Assumes ram_defs.svh is on the include path.
`include "ram_defs.svh"
package ram_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [23:0] addr;
    logic [31:0] wdata;
  } req_s;
  typedef struct packed {
    logic ack;
    logic err;
    logic mmr;
    logic [31:0] rdata;
  } rsp_s;
  typedef struct packed {
    logic hit;
    logic mmr;
    logic [5:0] blk;
    logic [11:0] off;
  } dec_s;
endpackage

// ---- logic/onchip_ram_block_decode.sv ----
// On-chip RAM: 8 dual-access and 32 single-access blocks behind eight masters.
// Assumes all masters run on MCLK_IN and react to RSP_OUT.ack in the same cycle.
`timescale 1ns/1ps
`include "ram_defs.svh"

// Functional notes
// RULE_01: CPU bytes 000000h-00FFFFh hit eight dual-access blocks of 4K words.
// RULE_02: A dual-access block serves two accesses per cycle, any read/write mix.
// RULE_03: Program, data and DMA buses all reach the dual-access blocks.
// RULE_04: DMA sees dual-access block n at its CPU address plus 0001 0000h.
// RULE_05: Lowest 192 bytes of block 0 decode as CPU mapped registers.
// RULE_06: CPU bytes 010000h-04FFFFh hit 32 single-access blocks of 4K words.
// RULE_07: A single-access block serves at most one access per cycle.
// RULE_08: Program, data, DMA and USB DMA buses reach single-access blocks.
// RULE_09: DMA and USB see single-access blocks from 0009 0000h in 8 KB steps.
// RULE_10: Masters leave bytes 0x4E000-0x4EFFF alone while booting.
// RULE_11: One program, one 32-bit and two 16-bit read, two 16-bit write buses.
// RULE_12: The DMA port completes one 32-bit transfer per cycle, beside the CPU.
// RULE_13: CPU space is a unified 16M byte space, apart from I/O space.
// RULE_14: Excess requests to a block stall until a later cycle, none lost.
module onchip_ram_block_decode (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  input wire ram_pkg::req_s [`RAM_MASTERS-1:0] REQ_IN,
  output ram_pkg::rsp_s [`RAM_MASTERS-1:0] RSP_OUT
);

  // ****************************************************************
  // Decode and arbitration
  // ****************************************************************
  logic [15:0] mem [0:`RAM_ALL_BLOCKS*`RAM_BLOCK_WORDS-1];
  ram_pkg::dec_s dec [`RAM_MASTERS];
  logic [`RAM_MASTERS-1:0] grant;
  logic [`RAM_MASTERS-1:0] taken;
  logic [`RAM_MASTERS-1:0] wide_eff;
  logic [1:0] used [`RAM_ALL_BLOCKS];
  ram_pkg::rsp_s [`RAM_MASTERS-1:0] rsp_reg;
  ram_pkg::rsp_s [`RAM_MASTERS-1:0] rsp_next;

  function automatic ram_pkg::dec_s decode(input int m, input logic [23:0] a);
    ram_pkg::dec_s d;
    logic [23:0] rel;
    d = '0;
    rel = '0;
    d.off = a[12:1];
    if (m == `RAM_M_DMA || m == `RAM_M_USB) begin
      if (m == `RAM_M_DMA && a >= `RAM_DMA_DP_LO && a <= `RAM_DMA_DP_HI) begin
        d.hit = 1'b1; // RULE_04
        d.blk = {3'h0, a[15:13]};
      end else if (a >= `RAM_DMA_SP_LO && a <= `RAM_DMA_SP_HI) begin
        rel = a - `RAM_DMA_SP_LO;
        d.hit = 1'b1; // RULE_09
        d.blk = 6'(rel[17:13]) + 6'h08;
      end
    end else if (a <= `RAM_CPU_DP_HI) begin
      d.hit = 1'b1; // RULE_01
      d.blk = {3'h0, a[15:13]};
      d.mmr = (a < `RAM_MMR_BYTES); // RULE_05
    end else if (a >= `RAM_CPU_SP_LO && a <= `RAM_CPU_SP_HI) begin
      rel = a - `RAM_CPU_SP_LO;
      d.hit = 1'b1; // RULE_06
      d.blk = 6'(rel[17:13]) + 6'h08;
    end
    return d;
  endfunction

  function automatic logic [17:0] widx(input ram_pkg::dec_s d, input logic odd);
    return {d.blk[5:0], d.off[11:1], odd};
  endfunction

  always_comb begin
    grant = '0;
    taken = '0;
    wide_eff = '0;
    for (int b = 0; b < `RAM_ALL_BLOCKS; b++) begin
      used[b] = 2'h0;
    end
    // DMA first so its port is never held off by the CPU
    for (int m = 0; m < `RAM_MASTERS; m++) begin
      dec[m] = decode(m, REQ_IN[m].addr); // RULE_13
      wide_eff[m] = REQ_IN[m].wide && m < `RAM_M_DR16A; // RULE_11
      if (REQ_IN[m].valid) begin
        if (!dec[m].hit || dec[m].mmr) begin
          taken[m] = 1'b1;
        end else if (used[dec[m].blk] < ((dec[m].blk < 6'h08) ? `RAM_DP_CAP : `RAM_SP_CAP)) begin
          used[dec[m].blk] = used[dec[m].blk] + 2'h1; // RULE_02 RULE_07
          grant[m] = 1'b1; // RULE_03 RULE_08 RULE_12
          taken[m] = 1'b1;
        end
        // Refused masters keep their request up and retry next cycle RULE_14
      end
    end
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  always_comb begin
    rsp_next = rsp_reg;
    for (int m = 0; m < `RAM_MASTERS; m++) begin
      rsp_next[m].ack = taken[m]; // RULE_14
      rsp_next[m].err = taken[m] && !dec[m].hit;
      rsp_next[m].mmr = taken[m] && dec[m].mmr;
      if (grant[m] && !REQ_IN[m].write) begin
        rsp_next[m].rdata = wide_eff[m] ?
          {mem[widx(dec[m], 1'b0)], mem[widx(dec[m], 1'b1)]} :
          {16'h0000, mem[{dec[m].blk, dec[m].off}]};
      end else if (taken[m]) begin
        rsp_next[m].rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      rsp_reg <= '0;
    end else if (CE_IN) begin
      rsp_reg <= rsp_next;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (CE_IN && !RESET_IN) begin
      for (int m = 0; m < `RAM_MASTERS; m++) begin
        if (grant[m] && REQ_IN[m].write) begin
          if (wide_eff[m]) begin
            mem[widx(dec[m], 1'b0)] <= REQ_IN[m].wdata[31:16];
            mem[widx(dec[m], 1'b1)] <= REQ_IN[m].wdata[15:0];
          end else begin
            mem[{dec[m].blk, dec[m].off}] <= REQ_IN[m].wdata[15:0];
          end
        end
      end
    end
  end

  assign RSP_OUT = rsp_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);

  property p_cpu_dp_map;
    REQ_IN[`RAM_M_DR16A].valid && CE_IN && REQ_IN[`RAM_M_DR16A].addr <= 24'h00FFFF
      && REQ_IN[`RAM_M_DR16A].addr >= 24'h0000C0 && grant[`RAM_M_DR16A]
      |=> RSP_OUT[`RAM_M_DR16A].ack && !RSP_OUT[`RAM_M_DR16A].err;
  endproperty
  a_cpu_dp_map: assert property (p_cpu_dp_map) else $error("dual block access failed"); // RULE_01

  // Grant counts of one dual and one single block, kept apart from the arbiter tally
  logic [3:0] dp_probe_grants;
  logic [3:0] sp_probe_grants;

  always_comb begin
    dp_probe_grants = 4'h0;
    sp_probe_grants = 4'h0;
    for (int m = 0; m < `RAM_MASTERS; m++) begin
      if (grant[m] && dec[m].blk == 6'h01) begin
        dp_probe_grants = dp_probe_grants + 4'h1;
      end
      if (grant[m] && dec[m].blk == 6'h27) begin
        sp_probe_grants = sp_probe_grants + 4'h1;
      end
    end
  end

  property p_dp_cap;
    dp_probe_grants <= 4'h2;
  endproperty
  a_dp_cap: assert property (p_dp_cap) else $error("dual block over capacity"); // RULE_02

  property p_prog_dp;
    REQ_IN[`RAM_M_PROG].valid && CE_IN && REQ_IN[`RAM_M_PROG].addr[23:16] == 8'h00
      ##0 taken[`RAM_M_PROG] |=> !RSP_OUT[`RAM_M_PROG].err;
  endproperty
  a_prog_dp: assert property (p_prog_dp) else $error("program bus refused"); // RULE_03

  property p_dma_dp;
    REQ_IN[`RAM_M_DMA].valid && CE_IN && REQ_IN[`RAM_M_DMA].addr[23:16] == 8'h01
      |=> RSP_OUT[`RAM_M_DMA].ack && !RSP_OUT[`RAM_M_DMA].err;
  endproperty
  a_dma_dp: assert property (p_dma_dp) else $error("dma dual window failed"); // RULE_04

  property p_mmr;
    REQ_IN[`RAM_M_DR32].valid && CE_IN && REQ_IN[`RAM_M_DR32].addr < 24'h0000C0
      |=> RSP_OUT[`RAM_M_DR32].mmr && RSP_OUT[`RAM_M_DR32].ack;
  endproperty
  a_mmr: assert property (p_mmr) else $error("mapped register not flagged"); // RULE_05

  property p_sp_cap;
    sp_probe_grants <= 4'h1;
  endproperty
  a_sp_cap: assert property (p_sp_cap) else $error("single block over capacity"); // RULE_07

  property p_usb_dp_err;
    REQ_IN[`RAM_M_USB].valid && CE_IN && REQ_IN[`RAM_M_USB].addr[23:16] == 8'h01
      |=> RSP_OUT[`RAM_M_USB].err;
  endproperty
  a_usb_dp_err: assert property (p_usb_dp_err) else $error("usb reached dual block"); // RULE_08

  property p_usb_sp;
    REQ_IN[`RAM_M_USB].valid && CE_IN && REQ_IN[`RAM_M_USB].addr[23:16] == 8'h09
      && taken[`RAM_M_USB] |=> !RSP_OUT[`RAM_M_USB].err;
  endproperty
  a_usb_sp: assert property (p_usb_sp) else $error("usb single window failed"); // RULE_09

  property p_dma_every_cycle;
    REQ_IN[`RAM_M_DMA].valid && CE_IN |=> RSP_OUT[`RAM_M_DMA].ack;
  endproperty
  a_dma_every_cycle: assert property (p_dma_every_cycle) else $error("dma stalled"); // RULE_12

  property p_cpu_high_err;
    REQ_IN[`RAM_M_DR16B].valid && CE_IN && REQ_IN[`RAM_M_DR16B].addr > 24'h04FFFF
      |=> RSP_OUT[`RAM_M_DR16B].err;
  endproperty
  a_cpu_high_err: assert property (p_cpu_high_err) else $error("out of range accepted"); // RULE_13

  property p_stall;
    REQ_IN[`RAM_M_DW16B].valid && CE_IN && !taken[`RAM_M_DW16B]
      |=> !RSP_OUT[`RAM_M_DW16B].ack;
  endproperty
  a_stall: assert property (p_stall) else $error("stalled request answered"); // RULE_14

  c_dual_pair: cover property (used[2] == 2'h2);
  c_stall: cover property (REQ_IN[`RAM_M_DW16B].valid && !taken[`RAM_M_DW16B]);
  c_six_cpu: cover property (&grant[`RAM_M_DW16B:`RAM_M_PROG]);
  c_usb_sp: cover property (grant[`RAM_M_USB]);

endmodule

// ---- test/bus_masters.sv ----
// Behavioural model of the eight masters facing the RAM decoder.
// Assumes start_in pulses for one cycle and changes only after a rising edge.
`timescale 1ns/1ps
module bus_masters (
  input wire logic clk_in,
  input wire logic [7:0] start_in,
  input wire ram_pkg::req_s [7:0] cmd_in,
  input wire ram_pkg::rsp_s [7:0] rsp_in,
  output ram_pkg::req_s [7:0] req_out,
  output ram_pkg::rsp_s [7:0] got_out,
  output logic [7:0] busy_out
);
  initial req_out = '0;
  initial got_out = '0;
  always_comb for (int i = 0; i < 8; i++) busy_out[i] = req_out[i].valid;
  // Held until acknowledged; a released bus shows inverted leftovers
  always @(negedge clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (start_in[i]) begin
        req_out[i] <= cmd_in[i];
      end else if (req_out[i].valid && rsp_in[i].ack) begin
        got_out[i] <= rsp_in[i];
        req_out[i].valid <= 1'b0;
        req_out[i].addr <= ~req_out[i].addr;
        req_out[i].wdata <= ~req_out[i].wdata;
      end
    end
  end
endmodule

// ---- test/onchip_ram_block_decode_test.sv ----
// Self-checking bench of the on-chip RAM block decoder.
// Assumes bus_masters drives the request ports; no access enters the boot area.
`timescale 1ns/1ps
module onchip_ram_block_decode_test;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] start = '0;
  logic [7:0] busy;
  ram_pkg::req_s [7:0] cmd = '0;
  ram_pkg::req_s [7:0] req;
  ram_pkg::rsp_s [7:0] rsp;
  ram_pkg::rsp_s [7:0] got;
  logic [1:0] em [6] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0};
  int lat [8];
  int bad_count = 0;
  int check_count = 0;
  onchip_ram_block_decode dut_u (.MCLK_IN(mclk), .RESET_IN(reset), .CE_IN(ce),
    .REQ_IN(req), .RSP_OUT(rsp));
  bus_masters bm_u (.clk_in(mclk), .start_in(start), .cmd_in(cmd), .rsp_in(rsp),
    .req_out(req), .got_out(got), .busy_out(busy));
  initial forever #25 mclk = ~mclk;
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task put(input int m, input logic w, input logic wd, input logic [23:0] a,
    input logic [31:0] d);
    cmd[m] = '{1'b1, w, wd, a, d};
    start[m] = 1'b1;
  endtask
  // ****************************************
  // Issue queued requests, note ack cycles
  // ****************************************
  task run;
    int k;
    lat = '{default: 0};
    for (k = 1; k < 20; k++) begin
      @(posedge mclk);
      #1;
      if (k == 1) begin
        start = '0;
      end
      for (int i = 0; i < 8; i++) if (rsp[i].ack === 1'b1) lat[i] = k;
      if (k > 1 && busy === 8'h00) break;
    end
    if (k == 20) begin
      bad_count++;
      stop_test();
    end
  endtask
  task t_dual;
    put(0, 1'b1, 1'b1, 24'h012004, 32'h1234ABCD);
    put(6, 1'b1, 1'b0, 24'h002008, 32'h00005A5A);
    run();
    chk(lat[0], 1);
    chk(lat[6], 1);
    put(0, 1'b0, 1'b0, 24'h012008, 32'h0);
    put(2, 1'b0, 1'b0, 24'h002006, 32'h0);
    put(3, 1'b0, 1'b1, 24'h002006, 32'h0);
    put(4, 1'b0, 1'b0, 24'h002004, 32'h0);
    run();
    chk(lat[0] * 64 + lat[2] * 16 + lat[3] * 4 + lat[4], 32'h5A);
    chk(got[3].rdata, 32'h1234ABCD);
    chk(got[0].rdata[15:0], 32'h5A5A);
    chk(got[2].rdata[15:0], 32'hABCD);
    chk(got[4].rdata[15:0], 32'h1234);
    $display("t_dual done");
  endtask
  task t_single;
    put(1, 1'b1, 1'b0, 24'h0CF010, 32'h0000C3C3);
    put(2, 1'b1, 1'b0, 24'h04F012, 32'h00003C3C);
    put(5, 1'b0, 1'b0, 24'h010000, 32'h0);
    put(7, 1'b1, 1'b0, 24'h04F014, 32'h00007E7E);
    run();
    chk(lat[1] * 16 + lat[2] * 4 + lat[7], 32'h1B);
    chk(lat[5], 1);
    put(1, 1'b0, 1'b0, 24'h0CF012, 32'h0);
    put(3, 1'b0, 1'b0, 24'h04F010, 32'h0);
    run();
    chk(lat[1] * 4 + lat[3], 32'h6);
    chk(got[1].rdata[15:0], 32'h3C3C);
    chk(got[3].rdata[15:0], 32'hC3C3);
    $display("t_single done");
  endtask
  task t_map;
    put(0, 1'b0, 1'b0, 24'h0D0000, 32'h0);
    put(1, 1'b0, 1'b0, 24'h010000, 32'h0);
    put(2, 1'b0, 1'b0, 24'h0000BE, 32'h0);
    put(3, 1'b0, 1'b0, 24'h0000C0, 32'h0);
    put(4, 1'b0, 1'b0, 24'h050000, 32'h0);
    put(5, 1'b0, 1'b0, 24'h04FFFE, 32'h0);
    run();
    for (int i = 0; i < 6; i++) chk({got[i].err, got[i].mmr}, em[i]);
    chk(got[2].rdata, 32'h0);
    chk(lat[5], 1);
    $display("t_map done");
  endtask
  // Request held while the clock enable is low must survive and land afterwards
  task t_hold;
    put(6, 1'b1, 1'b0, 24'h00200A, 32'h0000A5A5);
    @(negedge mclk);
    ce = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(rsp[6].ack, 1'b0);
    @(negedge mclk);
    ce = 1'b1;
    run();
    chk(lat[6], 1);
    put(4, 1'b0, 1'b0, 24'h00200A, 32'h0);
    run();
    chk(got[4].rdata[15:0], 32'hA5A5);
    $display("t_hold done");
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    @(posedge mclk);
    #1;
    t_dual();
    t_single();
    t_map();
    t_hold();
    stop_test();
  end
endmodule
